/* dv/tb_video_color_pixel_format_pipeline.sv */
// Self-checking bench for the pixel pipeline.
`default_nettype none
module tb_video_color_pixel_format_pipeline;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, dma_wr_data, dma_rd_data, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [23:0] fe_in_data, fe_out_data;
	logic fe_in_valid, fe_in_ready, fe_in_sof, fe_in_eol, dma_wr_valid, dma_wr_ready, dma_wr_sof;
	logic dma_wr_eol, dma_rd_valid, dma_rd_ready, dma_rd_sof, dma_rd_eol, out_frame_new;
	logic fe_out_valid, fe_out_ready, fe_out_sof, fe_out_eol;
	logic [31:0] fmt [5] = '{0, 1, 2, 3, 5};
	logic [31:0] e0 [5] = '{'h11, 'h2211, 'h33_2211, 'h33_2211, 'h2211};
	logic [31:0] e1 [5] = '{'h44, 'h5544, 'h66_5544, 'h66_5544, 'h6644};
	logic [31:0] swp [12] = '{0, 0, 'h2000, 0, 'h2000, 0, 'h2000, 0, 0, 0, 0, 0};
	logic [25:0] out_q [$];
	int n_errors = 0, n_checks = 0, cyc = 0, i;
	vcpp_top #(.PPC(1)) dut (.*);
	vcpp_dma_model u_dma (.clk(clk), .wr_data(dma_wr_data), .wr_valid(dma_wr_valid),
		.wr_sof(dma_wr_sof), .wr_eol(dma_wr_eol),
		.wr_ready(dma_wr_ready), .rd_data(dma_rd_data), .rd_valid(dma_rd_valid),
		.rd_ready(dma_rd_ready), .rd_sof(dma_rd_sof), .rd_eol(dma_rd_eol));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ==================================================
	// Output sink with stalls, and the run limit
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		fe_out_ready <= (cyc % 5 != 4);
		if (fe_out_valid && fe_out_ready)
			out_q.push_back({fe_out_sof, fe_out_eol, fe_out_data});
		if (cyc == 40000)
		begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] hit;
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		// Each channel is released at the edge that takes it, in whichever order that comes.
		do
		begin
			@(negedge clk);
			hit = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready};
			@(posedge clk);
			if (hit[1])
				s_axi_awvalid <= 1'b0;
			if (hit[0])
				s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && !hit[1]) || (s_axi_wvalid && !hit[0]));
		do @(negedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic px(input logic [23:0] v, input logic s, input logic e);
		@(posedge clk);
		{fe_in_data, fe_in_valid, fe_in_sof, fe_in_eol} <= {v, 1'b1, s, e};
		do @(negedge clk); while (!fe_in_ready);
	endtask : px
	// A stray beat before the frame start and the next frame's start beat bracket the frame.
	task automatic capture(input logic [31:0] c, input logic [23:0] p0, input logic [23:0] p1,
		input logic [31:0] x0, input logic [31:0] x1);
		u_dma.wr_q.delete();
		u_dma.wr_m.delete();
		wr(8'h00, c);
		px(24'h77_7777, 1'b0, 1'b0);
		px(p0, 1'b1, 1'b0);
		px(p1, 1'b0, 1'b1);
		px(24'h99_9999, 1'b1, 1'b0);
		@(posedge clk);
		{fe_in_valid, fe_in_sof, fe_in_eol, fe_in_data} <= {3'h0, ~fe_in_data};
		for (i = 0; i < 64 && u_dma.wr_q.size() < 2; i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		chk(32'(u_dma.wr_q.size()), 32'h2);
		chk(u_dma.wr_q[0], x0);
		chk(u_dma.wr_q[1], x1);
		chk(32'({u_dma.wr_m[0], u_dma.wr_m[1]}), 32'h9);
	endtask : capture
	// ==================================================
	// Main sequence
	initial
	begin
		{rst, s_axi_wstrb} = 5'h1f;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, out_frame_new} = '0;
		{fe_in_data, fe_in_valid, fe_in_sof, fe_in_eol} = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(8'h08);
		chk(d, 32'h0000_0002);
		rd(8'h40);
		chk(d, 32'h0000_2000);
		rd(8'hfc);
		chk(d, 32'h0000_0000);
		chk({30'h0, r}, 32'h0000_0002);
		wr(8'hfc, 32'h0000_0001);
		chk({30'h0, r}, 32'h0000_0002);
		$display("register test done");
		for (int m = 0; m < 5; m++)
		begin
			wr(8'h08, fmt[m]);
			capture(32'h1, 24'h33_2211, 24'h66_5544, e0[m], e1[m]);
		end
		rd(8'h04);
		chk(d & 32'h0000_0004, 32'h0000_0004);
		wr(8'h04, 32'h0000_0004);
		rd(8'h04);
		chk(d & 32'h0000_0004, 32'h0000_0000);
		$display("packing test done");
		wr(8'h08, 32'h0000_0002);
		for (int k = 0; k < 12; k++)
			wr(8'(8'h40 + 4 * k), swp[k]);
		capture(32'h1, 24'h33_2211, 24'h66_5544, 32'h0011_2233, 32'h0044_5566);
		wr(8'h40, 32'h0000_c000);
		wr(8'h48, 32'h0000_0000);
		wr(8'h50, 32'h0000_2000);
		wr(8'h58, 32'h0000_0000);
		wr(8'h60, 32'h0000_2000);
		wr(8'h64, 32'h0000_1000);
		rd(8'h40);
		chk(d, 32'h0000_c000);
		capture(32'h1, 24'h66_5520, 24'h66_5510, 32'h0066_5540, 32'h0066_5560);
		$display("matrix test done");
		out_q.delete();
		u_dma.rd_beat(32'hffaa_bbcc, 1'b1, 1'b0);
		u_dma.rd_beat(32'h0012_3456, 1'b0, 1'b1);
		u_dma.rd_idle();
		wr(8'h0c, 32'h0000_0000);
		u_dma.rd_beat(32'h0000_00a5, 1'b1, 1'b1);
		u_dma.rd_idle();
		wr(8'h0c, 32'h0000_0005);
		u_dma.rd_beat(32'h0000_c1d2, 1'b1, 1'b0);
		u_dma.rd_beat(32'h0000_e3f4, 1'b0, 1'b1);
		u_dma.rd_idle();
		for (i = 0; i < 96 && out_q.size() < 5; i++)
			@(posedge clk);
		chk(32'(out_q.size()), 32'h5);
		chk(32'(out_q[0]), 32'h02aa_bbcc);
		chk(32'(out_q[1]), 32'h0112_3456);
		chk(32'(out_q[2]), 32'h03a5_a5a5);
		chk(32'(out_q[3] & 26'h300_ffff), 32'h0200_c1d2);
		chk(32'(out_q[4]), 32'h01e3_c1f4);
		$display("output test done");
		out_q.delete();
		capture(32'h3, 24'h66_5520, 24'h66_5510, 32'h0066_5540, 32'h0066_5560);
		chk(32'(out_q.size()), 32'h4);
		chk(32'(out_q[1]), 32'h0266_5520);
		chk(32'(out_q[2]), 32'h0166_5510);
		chk(32'(out_q[3]), 32'h0299_9999);
		rd(8'h04);
		chk(d & 32'h0000_0008, 32'h0000_0008);
		@(posedge clk);
		out_frame_new <= 1'b1;
		@(posedge clk);
		out_frame_new <= 1'b0;
		rd(8'h04);
		chk(d & 32'h0000_0008, 32'h0000_0000);
		$display("tie test done");
		print_verdict();
	end
endmodule : tb_video_color_pixel_format_pipeline
bind vcpp_top vcpp_assertions #(.PPC(PPC)) u_chk (.*);
`default_nettype wire

/* dv/vcpp_assertions.sv */
// Port-level checks for the pixel pipeline top.
`default_nettype none
module vcpp_assertions #(
	parameter int PPC = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [32*PPC-1:0] dma_wr_data,
	input wire logic dma_wr_valid,
	input wire logic dma_wr_ready,
	input wire logic dma_wr_sof,
	input wire logic dma_wr_eol,
	input wire logic [24*PPC-1:0] fe_out_data,
	input wire logic fe_out_valid,
	input wire logic fe_out_ready,
	input wire logic fe_out_sof,
	input wire logic fe_out_eol
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_wr_hold: assert property (dma_wr_valid && !dma_wr_ready |=> dma_wr_valid
		&& $stable({dma_wr_data, dma_wr_sof, dma_wr_eol})) else $error("dma beat changed in stall");
	a_out_hold: assert property (fe_out_valid && !fe_out_ready |=> fe_out_valid
		&& $stable({fe_out_data, fe_out_sof, fe_out_eol})) else $error("out beat changed in stall");
	a_aw_cond: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid
		&& !s_axi_bvalid && s_axi_wready) else $error("write taken out of turn");
	a_b_take: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("no write response after take");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_r_take: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data after take");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable({s_axi_rdata, s_axi_rresp})) else $error("read data changed in stall");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	cover property (dma_wr_valid && dma_wr_ready && dma_wr_sof);
	cover property (fe_out_valid && !fe_out_ready);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : vcpp_assertions
`default_nettype wire

/* dv/vcpp_dma_model.sv */
// Frame-buffer engine model: sinks captured beats, sources output beats.
`default_nettype none
module vcpp_dma_model (
	input wire logic clk,
	input wire logic [31:0] wr_data,
	input wire logic wr_valid,
	input wire logic wr_sof,
	input wire logic wr_eol,
	output logic wr_ready,
	output logic [31:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic rd_sof,
	output logic rd_eol
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt = 2'h0;
	logic [31:0] wr_q [$];
	logic [1:0] wr_m [$];
	initial
	begin
		{wr_ready, rd_valid, rd_sof, rd_eol, rd_data} = '0;
	end
	// Stalls one cycle in four so the pipeline must hold its beats.
	always @(posedge clk)
	begin
		cnt <= cnt + 2'h1;
		wr_ready <= (cnt != 2'h3);
		if (wr_valid && wr_ready)
		begin
			wr_q.push_back(wr_data);
			wr_m.push_back({wr_sof, wr_eol});
		end
	end
	task automatic rd_beat(input logic [31:0] d, input logic s, input logic e);
		@(posedge clk);
		rd_data <= d;
		rd_valid <= 1'b1;
		rd_sof <= s;
		rd_eol <= e;
		do @(negedge clk); while (!rd_ready);
	endtask : rd_beat
	// Released data shows a changed pattern so a stale beat cannot pass as valid.
	task automatic rd_idle();
		@(posedge clk);
		{rd_valid, rd_sof, rd_eol} <= 3'h0;
		rd_data <= ~rd_data;
	endtask : rd_idle
endmodule : vcpp_dma_model
`default_nettype wire

/* hw/vcpp_csc.sv */
// Colour-space converter: a 3x4 coefficient matrix applied to every pixel lane.
`include "vcpp_map.svh"
`default_nettype none
module vcpp_csc #(
	parameter int PPC = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire vcpp_pkg::vcpp_coef_t coef [`VCPP_NCOEF],
	vcpp_stream_if.snk s,
	vcpp_stream_if.src m
);
	localparam int AW = `VCPP_COEF_W + 12;
	logic [24*PPC+2:0] q_q, q_d;
	logic [24*PPC-1:0] px;
	logic adv;

	// Weights are Q3.13 so any value from -2 to +2 is held exactly enough.
	function automatic logic [7:0] chan(input logic [23:0] p, input int r);
		logic signed [AW-1:0] acc;
		acc = AW'(coef[9+r]) <<< 8;
		for (int k = 0; k < 3; k++)
		begin
			acc = acc + AW'($signed({1'b0, p[8*k+:8]}) * coef[3*r+k]);
		end
		if (acc[AW-1])
			chan = 8'h00;
		else if (|acc[AW-2:`VCPP_COEF_FRAC+8])
			chan = 8'hff;
		else
			chan = acc[`VCPP_COEF_FRAC+:8];
	endfunction : chan

	// ==================================================
	// Per-lane arithmetic
	for (genvar l = 0; l < PPC; l++)
	begin : g_lane
		for (genvar o = 0; o < 3; o++)
		begin : g_out
			always_comb px[24*l+8*o+:8] = chan(s.data[24*l+:24], o);
		end
	end

	// ==================================================
	// Output register
	assign adv = !q_q[24*PPC+2] || m.ready;
	assign s.ready = adv;
	assign m.valid = q_q[24*PPC+2];
	assign m.sof = q_q[24*PPC+1];
	assign m.eol = q_q[24*PPC];
	assign m.data = q_q[24*PPC-1:0];

	always_comb
	begin
		q_d = q_q;
		if (adv)
			q_d = {s.valid, s.sof, s.eol, px};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q_q <= '0;
		else
			q_q <= q_d;
	end
endmodule : vcpp_csc
`default_nettype wire

/* hw/vcpp_map.svh */
// Register offsets, field positions and reset values of the pixel pipeline.
`ifndef VCPP_MAP_SVH
`define VCPP_MAP_SVH

// ==================================================
// Register byte offsets, and the address bits 7:6 that select each coefficient bank
`define VCPP_A_CTRL 8'h00
`define VCPP_A_STAT 8'h04
`define VCPP_A_IFMT 8'h08
`define VCPP_A_OFMT 8'h0c
`define VCPP_A_CIN 2'h1
`define VCPP_A_COUT 2'h2

// ==================================================
// Fields
`define VCPP_CTRL_RD 0
`define VCPP_CTRL_TIE 1
`define VCPP_ST_ARMED 0
`define VCPP_ST_CAPT 1
`define VCPP_ST_DONE 2
`define VCPP_ST_TIE 3
`define VCPP_FMT_RES 2

// ==================================================
// Constants
`define VCPP_NCOEF 12
`define VCPP_COEF_W 16
`define VCPP_COEF_FRAC 13
`define VCPP_COEF_ONE 16'h2000
`define VCPP_PAD 8'h00
`define VCPP_OKAY 2'h0
`define VCPP_SLVERR 2'h2
`define VCPP_COEF_RST(k) ((((k) == 0) || ((k) == 4) || ((k) == 8)) ? `VCPP_COEF_ONE : 16'h0000)

`endif

/* hw/vcpp_pkg.sv */
// Types shared by the pixel pipeline modules.
`include "vcpp_map.svh"
`default_nettype none
package vcpp_pkg;
	typedef enum logic [1:0] {
		VCPP_BPP8 = 2'h0,
		VCPP_BPP16 = 2'h1,
		VCPP_BPP24 = 2'h2,
		VCPP_BPP32 = 2'h3
	} vcpp_bpp_e;
	typedef enum logic [2:0] {
		VCPP_IDLE = 3'h1,
		VCPP_ARMED = 3'h2,
		VCPP_CAPT = 3'h4
	} vcpp_cap_e;
	typedef logic signed [`VCPP_COEF_W-1:0] vcpp_coef_t;
	typedef struct {
		logic tie;
		logic done;
		vcpp_bpp_e ibpp;
		logic ires;
		vcpp_bpp_e obpp;
		logic ores;
		vcpp_coef_t cin [`VCPP_NCOEF];
		vcpp_coef_t cout [`VCPP_NCOEF];
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} vcpp_regs_s;
endpackage : vcpp_pkg
`default_nettype wire

/* hw/vcpp_stream_if.sv */
// Valid/ready pixel stream between pipeline stages.
`default_nettype none
interface vcpp_stream_if #(parameter int DW = 24) ();
	logic valid;
	logic ready;
	logic sof;
	logic eol;
	logic [DW-1:0] data;
	modport src (output valid, output sof, output eol, output data, input ready);
	modport snk (input valid, input sof, input eol, input data, output ready);
endinterface : vcpp_stream_if
`default_nettype wire

/* hw/vcpp_top.sv */
// Pixel pipeline: capture, colour conversion, packing, unpacking and output tie.
// ==================================================
// Overview of operation
// - The input stream carries 24-bit pixels, channels blue, green, red from bit 0 up.
// - The converter treats every pixel alone with a three by four coefficient matrix.
// - Each output channel is three weighted inputs plus a bias: c1-c3/c10, c4-c6/c11, c7-c9/c12.
// - Coefficients are signed fractions covering minus two to plus two.
// - The coefficient sets for RGB, RGBA, BGR (default), YCbCr and grayscale are all loadable.
// - Eight-bit packing keeps the first channel and drops the other two.
// - Sixteen-bit packing keeps two channels, or first plus alternating chroma for 4:2:2.
// - Twenty-four-bit packing passes each pixel unchanged.
// - Thirty-two-bit packing appends eight pad bits to each pixel.
// - Every stage talks over a valid/ready stream so a custom stage can be inserted.
// - The single-lane build moves one pixel per clock.
// - The wide build carries two pixels per clock.
// - The output path keeps showing the frame last supplied until a new one arrives.
// - A read returns the next wholly received frame and waits until one is complete.
// - A tie sends the raw input to the output, capture still works, a new frame ends it.
`include "vcpp_map.svh"
`default_nettype none
module vcpp_top #(
	parameter int PPC = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [24*PPC-1:0] fe_in_data,
	input wire logic fe_in_valid,
	output logic fe_in_ready,
	input wire logic fe_in_sof,
	input wire logic fe_in_eol,
	output logic [32*PPC-1:0] dma_wr_data,
	output logic dma_wr_valid,
	input wire logic dma_wr_ready,
	output logic dma_wr_sof,
	output logic dma_wr_eol,
	input wire logic [32*PPC-1:0] dma_rd_data,
	input wire logic dma_rd_valid,
	output logic dma_rd_ready,
	input wire logic dma_rd_sof,
	input wire logic dma_rd_eol,
	input wire logic out_frame_new,
	output logic [24*PPC-1:0] fe_out_data,
	output logic fe_out_valid,
	input wire logic fe_out_ready,
	output logic fe_out_sof,
	output logic fe_out_eol
);
	localparam int IW = 24 * PPC;
	localparam int OW = 32 * PPC;
	localparam logic PODD = PPC[0];

	vcpp_pkg::vcpp_regs_s r_q, r_d;
	vcpp_pkg::vcpp_cap_e cap_q, cap_d;
	logic wr_en, rd_req, cap_done, fwd, in_take, o_adv;
	logic [7:0] wa, ra;
	logic [OW+2:0] pk_q, pk_d;
	logic [IW+2:0] up_q, up_d, fo_q, fo_d;
	logic pk_par_q, pk_par_d, up_par_q, up_par_d;
	logic [7:0] h2_q, h2_d, h3_q, h3_d;
	logic [OW-1:0] pk_px;
	logic [IW-1:0] up_px;

	vcpp_stream_if #(.DW(IW)) ci ();
	vcpp_stream_if #(.DW(IW)) cm ();
	vcpp_stream_if #(.DW(IW)) uo ();
	vcpp_stream_if #(.DW(IW)) co ();

	// ==================================================
	// Register bus
	assign wa = {s_axi_awaddr[7:2], 2'h0};
	assign ra = {s_axi_araddr[7:2], 2'h0};
	// Address and data are taken together; this keeps one write in flight.
	assign wr_en = s_axi_awvalid && s_axi_wvalid && !r_q.bvalid;
	assign s_axi_awready = wr_en;
	assign s_axi_wready = wr_en;
	assign s_axi_bvalid = r_q.bvalid;
	assign s_axi_bresp = r_q.bresp;
	assign s_axi_arready = !r_q.rvalid;
	assign s_axi_rvalid = r_q.rvalid;
	assign s_axi_rresp = r_q.rresp;
	assign s_axi_rdata = r_q.rdata;

	always_comb
	begin
		r_d = r_q;
		rd_req = 1'b0;
		if (r_q.bvalid && s_axi_bready)
			r_d.bvalid = 1'b0;
		if (r_q.rvalid && s_axi_rready)
			r_d.rvalid = 1'b0;
		if (out_frame_new)
			r_d.tie = 1'b0;
		if (wr_en)
		begin
			r_d.bvalid = 1'b1;
			r_d.bresp = `VCPP_OKAY;
			if (wa == `VCPP_A_CTRL)
			begin
				if (s_axi_wstrb[0])
				begin
					rd_req = s_axi_wdata[`VCPP_CTRL_RD];
					r_d.tie = s_axi_wdata[`VCPP_CTRL_TIE];
				end
			end
			else if (wa == `VCPP_A_STAT)
			begin
				if (s_axi_wstrb[0] && s_axi_wdata[`VCPP_ST_DONE])
					r_d.done = 1'b0;
			end
			else if (wa == `VCPP_A_IFMT)
			begin
				if (s_axi_wstrb[0])
				begin
					r_d.ibpp = vcpp_pkg::vcpp_bpp_e'(s_axi_wdata[1:0]);
					r_d.ires = s_axi_wdata[`VCPP_FMT_RES];
				end
			end
			else if (wa == `VCPP_A_OFMT)
			begin
				if (s_axi_wstrb[0])
				begin
					r_d.obpp = vcpp_pkg::vcpp_bpp_e'(s_axi_wdata[1:0]);
					r_d.ores = s_axi_wdata[`VCPP_FMT_RES];
				end
			end
			else if (wa[5:2] < 4'(`VCPP_NCOEF) && wa[7:6] == `VCPP_A_CIN)
			begin
				for (int b = 0; b < 2; b++)
				begin
					if (s_axi_wstrb[b])
						r_d.cin[wa[5:2]][8*b+:8] = s_axi_wdata[8*b+:8];
				end
			end
			else if (wa[5:2] < 4'(`VCPP_NCOEF) && wa[7:6] == `VCPP_A_COUT)
			begin
				for (int b = 0; b < 2; b++)
				begin
					if (s_axi_wstrb[b])
						r_d.cout[wa[5:2]][8*b+:8] = s_axi_wdata[8*b+:8];
				end
			end
			else
				r_d.bresp = `VCPP_SLVERR;
		end
		// A frame that completes in the clearing cycle still leaves the flag set.
		if (cap_done)
			r_d.done = 1'b1;
		if (s_axi_arvalid && !r_q.rvalid)
		begin
			r_d.rvalid = 1'b1;
			r_d.rresp = `VCPP_OKAY;
			r_d.rdata = 32'h0000_0000;
			if (ra == `VCPP_A_CTRL)
				r_d.rdata[`VCPP_CTRL_TIE] = r_q.tie;
			else if (ra == `VCPP_A_STAT)
			begin
				r_d.rdata[`VCPP_ST_ARMED] = (cap_q == vcpp_pkg::VCPP_ARMED);
				r_d.rdata[`VCPP_ST_CAPT] = (cap_q == vcpp_pkg::VCPP_CAPT);
				r_d.rdata[`VCPP_ST_DONE] = r_q.done;
				r_d.rdata[`VCPP_ST_TIE] = r_q.tie;
			end
			else if (ra == `VCPP_A_IFMT)
				r_d.rdata[2:0] = {r_q.ires, r_q.ibpp};
			else if (ra == `VCPP_A_OFMT)
				r_d.rdata[2:0] = {r_q.ores, r_q.obpp};
			else if (ra[5:2] < 4'(`VCPP_NCOEF) && ra[7:6] == `VCPP_A_CIN)
				r_d.rdata = 32'(unsigned'(r_q.cin[ra[5:2]]));
			else if (ra[5:2] < 4'(`VCPP_NCOEF) && ra[7:6] == `VCPP_A_COUT)
				r_d.rdata = 32'(unsigned'(r_q.cout[ra[5:2]]));
			else
				r_d.rresp = `VCPP_SLVERR;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			r_q.tie <= 1'b0;
			r_q.done <= 1'b0;
			r_q.ibpp <= vcpp_pkg::VCPP_BPP24;
			r_q.ires <= 1'b0;
			r_q.obpp <= vcpp_pkg::VCPP_BPP24;
			r_q.ores <= 1'b0;
			r_q.bvalid <= 1'b0;
			r_q.bresp <= `VCPP_OKAY;
			r_q.rvalid <= 1'b0;
			r_q.rresp <= `VCPP_OKAY;
			r_q.rdata <= 32'h0000_0000;
			for (int k = 0; k < `VCPP_NCOEF; k++)
			begin
				r_q.cin[k] <= `VCPP_COEF_RST(k);
				r_q.cout[k] <= `VCPP_COEF_RST(k);
			end
		end
		else
			r_q <= r_d;
	end

	// ==================================================
	// Frame capture and tie fork
	// Capture starts only at a frame start, so the frame handed on is always whole.
	assign fwd = (cap_q == vcpp_pkg::VCPP_ARMED && fe_in_sof) ||
		(cap_q == vcpp_pkg::VCPP_CAPT && !fe_in_sof);
	assign o_adv = !fo_q[IW+2] || fe_out_ready;
	assign fe_in_ready = (!fwd || ci.ready) && (!r_q.tie || o_adv);
	assign in_take = fe_in_valid && fe_in_ready;
	assign ci.valid = fe_in_valid && fwd && (!r_q.tie || o_adv);
	assign ci.sof = fe_in_sof;
	assign ci.eol = fe_in_eol;
	assign ci.data = fe_in_data;

	always_comb
	begin
		cap_d = cap_q;
		cap_done = 1'b0;
		case (cap_q)
			vcpp_pkg::VCPP_IDLE:
				if (rd_req)
					cap_d = vcpp_pkg::VCPP_ARMED;
			vcpp_pkg::VCPP_ARMED:
				if (in_take && fe_in_sof)
					cap_d = vcpp_pkg::VCPP_CAPT;
			vcpp_pkg::VCPP_CAPT:
				if (in_take && fe_in_sof)
				begin
					cap_d = vcpp_pkg::VCPP_IDLE;
					cap_done = 1'b1;
				end
			default:
				cap_d = vcpp_pkg::VCPP_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cap_q <= vcpp_pkg::VCPP_IDLE;
		else
			cap_q <= cap_d;
	end

	vcpp_csc #(.PPC(PPC)) u_csc_in (
		.clk(clk),
		.rst(rst),
		.coef(r_q.cin),
		.s(ci.snk),
		.m(cm.src)
	);

	// ==================================================
	// Packer
	function automatic logic [31:0] pack_px(input logic [23:0] p, input vcpp_pkg::vcpp_bpp_e m,
		input logic rs, input logic odd);
		case (m)
			vcpp_pkg::VCPP_BPP8: pack_px = 32'(p[7:0]);
			vcpp_pkg::VCPP_BPP16: pack_px = 32'({(rs && odd) ? p[23:16] : p[15:8], p[7:0]});
			vcpp_pkg::VCPP_BPP24: pack_px = 32'(p);
			default: pack_px = {`VCPP_PAD, p};
		endcase
	endfunction : pack_px

	for (genvar l = 0; l < PPC; l++)
	begin : g_pack
		always_comb pk_px[32*l+:32] = pack_px(cm.data[24*l+:24], r_q.ibpp, r_q.ires,
			(cm.sof ? 1'b0 : pk_par_q) ^ 1'(l % 2));
	end

	assign cm.ready = !pk_q[OW+2] || dma_wr_ready;
	assign dma_wr_valid = pk_q[OW+2];
	assign dma_wr_sof = pk_q[OW+1];
	assign dma_wr_eol = pk_q[OW];
	assign dma_wr_data = pk_q[OW-1:0];

	always_comb
	begin
		pk_d = pk_q;
		pk_par_d = pk_par_q;
		if (cm.ready)
			pk_d = {cm.valid, cm.sof, cm.eol, pk_px};
		if (cm.ready && cm.valid)
			pk_par_d = cm.eol ? 1'b0 : ((cm.sof ? 1'b0 : pk_par_q) ^ PODD);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pk_q <= '0;
			pk_par_q <= 1'b0;
		end
		else
		begin
			pk_q <= pk_d;
			pk_par_q <= pk_par_d;
		end
	end

	// ==================================================
	// Unpacker
	// Missing chroma of a 4:2:2 pixel repeats the last one seen of that kind.
	function automatic logic [23:0] unpack_px(input logic [31:0] d, input vcpp_pkg::vcpp_bpp_e m,
		input logic rs, input logic odd, input logic [7:0] c2, input logic [7:0] c3);
		case (m)
			vcpp_pkg::VCPP_BPP8: unpack_px = {3{d[7:0]}};
			vcpp_pkg::VCPP_BPP16:
				if (!rs)
					unpack_px = {8'h00, d[15:0]};
				else if (odd)
					unpack_px = {d[15:8], c2, d[7:0]};
				else
					unpack_px = {c3, d[15:0]};
			default: unpack_px = d[23:0];
		endcase
	endfunction : unpack_px

	for (genvar l = 0; l < PPC; l++)
	begin : g_unpack
		always_comb up_px[24*l+:24] = unpack_px(dma_rd_data[32*l+:32], r_q.obpp, r_q.ores,
			(dma_rd_sof ? 1'b0 : up_par_q) ^ 1'(l % 2), h2_q, h3_q);
	end

	// The reader replays the last frame it was given; no beat is dropped here.
	assign dma_rd_ready = !up_q[IW+2] || uo.ready;
	assign uo.valid = up_q[IW+2];
	assign uo.sof = up_q[IW+1];
	assign uo.eol = up_q[IW];
	assign uo.data = up_q[IW-1:0];

	always_comb
	begin
		up_d = up_q;
		up_par_d = up_par_q;
		h2_d = h2_q;
		h3_d = h3_q;
		if (dma_rd_ready)
			up_d = {dma_rd_valid, dma_rd_sof, dma_rd_eol, up_px};
		if (dma_rd_ready && dma_rd_valid)
		begin
			up_par_d = dma_rd_eol ? 1'b0 : ((dma_rd_sof ? 1'b0 : up_par_q) ^ PODD);
			for (int l = 0; l < PPC; l++)
			begin
				if (((dma_rd_sof ? 1'b0 : up_par_q) ^ 1'(l % 2)) == 1'b1)
					h3_d = dma_rd_data[32*l+8+:8];
				else
					h2_d = dma_rd_data[32*l+8+:8];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			up_q <= '0;
			up_par_q <= 1'b0;
			h2_q <= 8'h00;
			h3_q <= 8'h00;
		end
		else
		begin
			up_q <= up_d;
			up_par_q <= up_par_d;
			h2_q <= h2_d;
			h3_q <= h3_d;
		end
	end

	vcpp_csc #(.PPC(PPC)) u_csc_out (
		.clk(clk),
		.rst(rst),
		.coef(r_q.cout),
		.s(uo.snk),
		.m(co.src)
	);

	// ==================================================
	// Output stage
	// While tied the converted path is stalled rather than drained, so it resumes cleanly.
	assign co.ready = !r_q.tie && o_adv;
	assign fe_out_valid = fo_q[IW+2];
	assign fe_out_sof = fo_q[IW+1];
	assign fe_out_eol = fo_q[IW];
	assign fe_out_data = fo_q[IW-1:0];

	always_comb
	begin
		fo_d = fo_q;
		if (o_adv)
		begin
			if (r_q.tie)
				fo_d = {in_take, fe_in_sof, fe_in_eol, fe_in_data};
			else
				fo_d = {co.valid, co.sof, co.eol, co.data};
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			fo_q <= '0;
		else
			fo_q <= fo_d;
	end
endmodule : vcpp_top
`default_nettype wire
